// ---- shared/fom_meas_if.sv ----
// carrier between the register front end and the measurement engine
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface fom_meas_if;
	logic                         start;
	logic [fom_pkg::SEL_W-1:0]    select;
	logic                         done;
	logic                         done_pulse;
	logic                         phase;
	logic [fom_pkg::CNT_W-1:0]    count;

	modport ctrl  (output start, output select, input done, input done_pulse, input phase, input count);
	modport meter (input start, input select, output done, output done_pulse, output phase, output count);
endinterface

// ---- shared/fom_pkg.sv ----
// constants, register map and state encoding for the frame offset measurement block
// assumes a 32-bit apb slave with 8-bit byte addresses; registers hold 16 bits in the low half
package fom_pkg;

	// ==========================================================
	// register map (byte addresses, one aligned word each)
	localparam logic [7:0] ADDR_ALIGNMENT_RESULT = 8'h00;
	localparam logic [7:0] ADDR_MODE_SELECT      = 8'h04;
	localparam logic [7:0] ADDR_STREAM_OFS_0_3   = 8'h08;
	localparam logic [7:0] ADDR_STREAM_OFS_4_7   = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STATUS       = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK         = 8'h14;

	// ==========================================================
	// field layout
	localparam int REG_W           = 16;
	localparam int SEL_W           = 5;
	localparam int SEL_LO          = 11;
	localparam int DONE_BIT        = 10;
	localparam int PHASE_BIT       = 9;
	localparam int CNT_W           = 9;
	localparam int START_BIT       = 0;
	localparam int IRQ_DONE_BIT    = 0;
	localparam int NUM_INPUTS      = 24;
	localparam int NUM_STREAMS     = 8;
	localparam int STREAMS_PER_REG = 4;
	localparam int NIB_W           = 4;
	localparam int OFS_W           = 3;
	localparam int SYNC_W          = NUM_INPUTS + 2;
	localparam int SYNC_BCLK       = NUM_INPUTS;
	localparam int SYNC_FRAME      = NUM_INPUTS + 1;

	// ==========================================================
	// reset values and limits
	localparam logic [REG_W-1:0] RST_REG16 = 16'h0000;
	localparam logic [SEL_W-1:0] RST_SEL   = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE   = 9'h001;
	localparam logic [CNT_W-1:0] CNT_MAX   = 9'h1ff;
	localparam logic [31:0]      RD_ZERO   = 32'h0000_0000;

	// ==========================================================
	// measurement sequencer states
	typedef enum logic [1:0] {
		ST_IDLE       = 2'b00,
		ST_WAIT_FRAME = 2'b01,
		ST_COUNT      = 2'b10,
		ST_DONE       = 2'b11
	} fom_state_e;

endpackage

// ---- src/fom_meter.sv ----
// measurement engine: synchronises the evaluation inputs, bit clock and device frame pulse,
// counts bit clocks from device frame start to the falling edge of the selected input
// assumes pins are asynchronous to the system clock and are slower than half its rate
`timescale 1ns/10ps
module fom_meter (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// raw pins
	input  wire logic [fom_pkg::NUM_INPUTS-1:0] eval_input_lines,
	input  wire logic                           bit_clk,
	input  wire logic                           frame_sync_n,
	// control side
	fom_meas_if.meter                           m
);

	// ==========================================================
	// input synchronisers
	logic [fom_pkg::SYNC_W-1:0] raw_in;
	logic [fom_pkg::SYNC_W-1:0] sync1_reg;
	logic [fom_pkg::SYNC_W-1:0] sync2_reg;

	assign raw_in = {frame_sync_n, bit_clk, eval_input_lines};

	// two flops per pin; the first stage feeds nothing but the second
	genvar gi;
	generate
		for (gi = 0; gi < fom_pkg::SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					sync1_reg[gi] <= 1'b1;
					sync2_reg[gi] <= 1'b1;
				end else begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// input selection and edge detection
	// an index past the last input reads as idle high, so it completes only when the count saturates
	function automatic logic pick_line(input logic [fom_pkg::NUM_INPUTS-1:0] lines,
	                                   input logic [fom_pkg::SEL_W-1:0] idx);
		if (idx < fom_pkg::SEL_W'(fom_pkg::NUM_INPUTS))
			return lines[idx];
		return 1'b1;
	endfunction

	logic       sel_sig;
	logic       bclk_s;
	logic       frame_s;
	logic       sel_prev_reg;
	logic       bclk_prev_reg;
	logic       frame_prev_reg;
	logic       start_prev_reg;
	logic       sel_fall;
	logic       bclk_rise;
	logic       frame_fall;
	logic       start_rise;
	logic       start_fall;

	assign sel_sig    = pick_line(sync2_reg[fom_pkg::NUM_INPUTS-1:0], m.select);
	assign bclk_s     = sync2_reg[fom_pkg::SYNC_BCLK];
	assign frame_s    = sync2_reg[fom_pkg::SYNC_FRAME];
	assign sel_fall   = sel_prev_reg & ~sel_sig;
	assign bclk_rise  = ~bclk_prev_reg & bclk_s;
	assign frame_fall = frame_prev_reg & ~frame_s;
	assign start_rise = ~start_prev_reg & m.start;
	assign start_fall = start_prev_reg & ~m.start;

	// previous-value flops for the edge detectors
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_prev_reg   <= 1'b1;
			bclk_prev_reg  <= 1'b1;
			frame_prev_reg <= 1'b1;
			start_prev_reg <= 1'b0;
		end else begin
			sel_prev_reg   <= sel_sig;
			bclk_prev_reg  <= bclk_s;
			frame_prev_reg <= frame_s;
			start_prev_reg <= m.start;
		end
	end

	// ==========================================================
	// sequencer
	fom_pkg::fom_state_e         state_reg;
	fom_pkg::fom_state_e         state_next;
	logic [fom_pkg::CNT_W-1:0]   count_reg;
	logic [fom_pkg::CNT_W-1:0]   count_next;
	logic                        phase_reg;
	logic                        phase_next;
	logic                        done_pulse_reg;
	logic                        finish;

	// finishes on the input edge, or at saturation so a dead input cannot hang software
	assign finish = (state_reg == fom_pkg::ST_COUNT) && (sel_fall || count_reg == fom_pkg::CNT_MAX);

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		phase_next = phase_reg;
		case (state_reg)
			fom_pkg::ST_IDLE: begin
				if (start_rise)
					state_next = fom_pkg::ST_WAIT_FRAME;
			end
			fom_pkg::ST_WAIT_FRAME: begin
				if (frame_fall) begin
					state_next = fom_pkg::ST_COUNT;
					count_next = fom_pkg::CNT_ZERO;
				end
			end
			fom_pkg::ST_COUNT: begin
				if (finish) begin
					state_next = fom_pkg::ST_DONE;
					phase_next = bclk_s;
				end else if (bclk_rise)
					count_next = count_reg + fom_pkg::CNT_ONE;
			end
			fom_pkg::ST_DONE: begin
				state_next = fom_pkg::ST_DONE;
			end
			default: begin
				state_next = fom_pkg::ST_IDLE;
			end
		endcase
		// dropping the start bit abandons any measurement and clears the result
		if (start_fall) begin
			state_next = fom_pkg::ST_IDLE;
			count_next = fom_pkg::CNT_ZERO;
			phase_next = 1'b0;
		end
	end

	// state, count and phase flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg      <= fom_pkg::ST_IDLE;
			count_reg      <= fom_pkg::CNT_ZERO;
			phase_reg      <= 1'b0;
			done_pulse_reg <= 1'b0;
		end else begin
			state_reg      <= state_next;
			count_reg      <= count_next;
			phase_reg      <= phase_next;
			done_pulse_reg <= finish & ~start_fall;
		end
	end

	assign m.done       = (state_reg == fom_pkg::ST_DONE);
	assign m.done_pulse = done_pulse_reg;
	assign m.phase      = phase_reg;
	assign m.count      = count_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_fall_clears_result:   assert property ($fell(m.start) |=> (!m.done && m.count == 9'h000))
		else $error("result not cleared after start bit fell");
	a_rise_starts_wait:     assert property ((state_reg == fom_pkg::ST_IDLE && start_rise) |=> state_reg == fom_pkg::ST_WAIT_FRAME)
		else $error("measurement did not begin on start rise");
	a_done_holds_result:    assert property ((m.done && m.start) |=> ($stable(m.count) && $stable(m.phase)))
		else $error("result moved while complete");
	a_count_steps_one:      assert property ((state_reg == fom_pkg::ST_COUNT && bclk_rise)
	                                        && !finish && !start_fall |=> m.count == $past(m.count) + 9'h001)
		else $error("count did not step by one");
	a_phase_from_clock:     assert property ((finish && !start_fall) |=> (m.done && m.phase == $past(bclk_s)))
		else $error("phase bit not taken from bit clock");
	a_pulse_with_done:      assert property (m.done_pulse |-> (m.done && $past(state_reg) == fom_pkg::ST_COUNT))
		else $error("completion pulse without completion");

	c_full_measure:  cover property (state_reg == fom_pkg::ST_COUNT ##[1:600] m.done_pulse);
	c_abort_count:   cover property (state_reg == fom_pkg::ST_COUNT && start_fall);
	c_phase_high:    cover property (m.done_pulse && m.phase);

endmodule

// ---- src/fom_top.sv ----
// frame offset measurement block: apb register front end, interrupt and stream offset settings
// assumes an apb4 master on CLK_SYS and asynchronous evaluation, bit clock and frame pins
// assumes software polls bit 10 or waits for the interrupt before it trusts the offset
// a select of 24 or more never sees an edge and completes only when the count saturates
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module fom_top (
	// clock and reset
	input  wire logic                                         CLK_SYS,
	input  wire logic                                         RESET_N,
	// apb slave
	input  wire logic                                         PSEL,
	input  wire logic                                         PENABLE,
	input  wire logic                                         PWRITE,
	input  wire logic [7:0]                                   PADDR,
	input  wire logic [31:0]                                  PWDATA,
	input  wire logic [3:0]                                   PSTRB,
	output logic      [31:0]                                  PRDATA,
	output logic                                              PREADY,
	output logic                                              PSLVERR,
	// interrupt
	output logic                                              IRQ,
	// evaluation pins
	input  wire logic [fom_pkg::NUM_INPUTS-1:0]               EVAL_INPUT_LINES,
	input  wire logic                                         BIT_CLK,
	input  wire logic                                         FRAME_SYNC_N,
	// per-stream receiver settings
	output logic      [fom_pkg::NUM_STREAMS*fom_pkg::OFS_W-1:0] STREAM_IN_OFFSET,
	output logic      [fom_pkg::NUM_STREAMS-1:0]              STREAM_OFFSET_FLAG
);

	// ==========================================================
	// register decode helpers
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return (addr[7:2] == ofs[7:2]);
	endfunction

	// byte-lane merge for the 16-bit registers; lanes 2 and 3 carry nothing
	function automatic logic [fom_pkg::REG_W-1:0] merge16(input logic [fom_pkg::REG_W-1:0] old,
	                                                     input logic [31:0] wd, input logic [3:0] strb);
		logic [fom_pkg::REG_W-1:0] res;
		res = old;
		if (strb[0])
			res[7:0] = wd[7:0];
		if (strb[1])
			res[15:8] = wd[15:8];
		return res;
	endfunction

	// ==========================================================
	// measurement engine
	fom_meas_if meas ();

	fom_meter fom_meter_i (
		.clk              (CLK_SYS),
		.rst_n            (RESET_N),
		.eval_input_lines (EVAL_INPUT_LINES),
		.bit_clk          (BIT_CLK),
		.frame_sync_n     (FRAME_SYNC_N),
		.m                (meas.meter)
	);

	// ==========================================================
	// apb handshake
	// one wait state buys a registered read path; every answer takes two access cycles
	// pslverr flags unmapped words only; writes to read-only fields are dropped quietly
	logic                        pready_reg;
	logic                        pslverr_reg;
	logic [31:0]                 prdata_reg;
	logic                        apb_access;
	logic                        apb_done;
	logic                        wr_en;
	logic                        hit_align;
	logic                        hit_mode;
	logic                        hit_ofs0;
	logic                        hit_ofs1;
	logic                        hit_stat;
	logic                        hit_mask;
	logic                        hit_any;

	assign apb_access = PSEL & PENABLE;
	assign apb_done   = apb_access & pready_reg;
	assign wr_en      = apb_done & PWRITE;
	assign hit_align  = hit(PADDR, fom_pkg::ADDR_ALIGNMENT_RESULT);
	assign hit_mode   = hit(PADDR, fom_pkg::ADDR_MODE_SELECT);
	assign hit_ofs0   = hit(PADDR, fom_pkg::ADDR_STREAM_OFS_0_3);
	assign hit_ofs1   = hit(PADDR, fom_pkg::ADDR_STREAM_OFS_4_7);
	assign hit_stat   = hit(PADDR, fom_pkg::ADDR_IRQ_STATUS);
	assign hit_mask   = hit(PADDR, fom_pkg::ADDR_IRQ_MASK);
	assign hit_any    = hit_align | hit_mode | hit_ofs0 | hit_ofs1 | hit_stat | hit_mask;

	// ==========================================================
	// software registers
	logic [fom_pkg::SEL_W-1:0]   sel_reg;
	logic                        start_reg;
	logic [fom_pkg::REG_W-1:0]   ofs0_reg;
	logic [fom_pkg::REG_W-1:0]   ofs1_reg;
	logic                        irq_stat_reg;
	logic                        irq_mask_reg;
	logic                        irq_reg;
	logic [fom_pkg::REG_W-1:0]   align_wr;
	logic [fom_pkg::REG_W-1:0]   mode_wr;
	logic [fom_pkg::REG_W-1:0]   stat_wr;
	logic [fom_pkg::REG_W-1:0]   mask_wr;
	logic [fom_pkg::REG_W-1:0]   align_rd;
	logic                        irq_stat_next;

	// only the select field of the alignment register is writable
	assign align_rd = {sel_reg, meas.done, meas.phase, meas.count};
	assign align_wr = merge16(align_rd, PWDATA, PSTRB);
	assign mode_wr  = merge16({15'h0000, start_reg}, PWDATA, PSTRB);
	assign stat_wr  = merge16(fom_pkg::RST_REG16, PWDATA, PSTRB);
	assign mask_wr  = merge16({15'h0000, irq_mask_reg}, PWDATA, PSTRB);

	// completion sets the sticky bit; a one written clears it, but a same-cycle set wins
	assign irq_stat_next = meas.done_pulse |
	                       (irq_stat_reg & ~(wr_en & hit_stat & stat_wr[fom_pkg::IRQ_DONE_BIT]));

	assign meas.start  = start_reg;
	assign meas.select = sel_reg;

	// select and start
	// writing a one over a one starts nothing; only a rise of the start bit counts
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			sel_reg   <= fom_pkg::RST_SEL;
			start_reg <= 1'b0;
		end else begin
			if (wr_en && hit_align)
				sel_reg <= align_wr[fom_pkg::SEL_LO +: fom_pkg::SEL_W];
			if (wr_en && hit_mode)
				start_reg <= mode_wr[fom_pkg::START_BIT];
		end
	end

	// stream offset registers
	// both share the merge helper so byte strobes behave alike in every register
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			ofs0_reg <= fom_pkg::RST_REG16;
			ofs1_reg <= fom_pkg::RST_REG16;
		end else begin
			if (wr_en && hit_ofs0)
				ofs0_reg <= merge16(ofs0_reg, PWDATA, PSTRB);
			if (wr_en && hit_ofs1)
				ofs1_reg <= merge16(ofs1_reg, PWDATA, PSTRB);
		end
	end

	// interrupt status, mask and output
	// the mask only gates the pin; masked completions still set the status bit
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			irq_stat_reg <= 1'b0;
			irq_mask_reg <= 1'b0;
			irq_reg      <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (wr_en && hit_mask)
				irq_mask_reg <= mask_wr[fom_pkg::IRQ_DONE_BIT];
			irq_reg      <= irq_stat_next & ((wr_en && hit_mask) ? mask_wr[fom_pkg::IRQ_DONE_BIT] : irq_mask_reg);
		end
	end

	// ==========================================================
	// read path
	// a read during counting shows a moving count; only a set bit 10 makes it an offset
	logic [fom_pkg::REG_W-1:0]   rd16;
	logic [31:0]                 rd_data;

	assign rd16 = hit_align ? align_rd :
	              hit_mode  ? {15'h0000, start_reg} :
	              hit_ofs0  ? ofs0_reg :
	              hit_ofs1  ? ofs1_reg :
	              hit_stat  ? {15'h0000, irq_stat_reg} :
	              hit_mask  ? {15'h0000, irq_mask_reg} :
	              fom_pkg::RST_REG16;
	assign rd_data = (hit_any && !PWRITE) ? {16'h0000, rd16} : fom_pkg::RD_ZERO;

	// answer flops; unmapped addresses answer with an error and zero data
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= fom_pkg::RD_ZERO;
		end else begin
			pready_reg  <= apb_access & ~pready_reg;
			pslverr_reg <= apb_access & ~pready_reg & ~hit_any;
			if (apb_access && !pready_reg)
				prdata_reg <= rd_data;
		end
	end

	// ==========================================================
	// stream offset fan-out
	// each nibble: offset bits 3..1 above the flag in bit 0
	logic [fom_pkg::NUM_STREAMS*fom_pkg::NIB_W-1:0]  ofs_all;
	logic [fom_pkg::NUM_STREAMS*fom_pkg::OFS_W-1:0]  in_ofs_wire;
	logic [fom_pkg::NUM_STREAMS-1:0]                 flag_wire;
	logic [fom_pkg::NUM_STREAMS*fom_pkg::OFS_W-1:0]  in_ofs_reg;
	logic [fom_pkg::NUM_STREAMS-1:0]                 flag_reg;

	assign ofs_all = {ofs1_reg, ofs0_reg};

	genvar gs;
	generate
		for (gs = 0; gs < fom_pkg::NUM_STREAMS; gs++) begin : g_stream
			assign in_ofs_wire[gs*fom_pkg::OFS_W +: fom_pkg::OFS_W] =
			       ofs_all[gs*fom_pkg::NIB_W + 1 +: fom_pkg::OFS_W];
			assign flag_wire[gs] = ofs_all[gs*fom_pkg::NIB_W];
		end
	endgenerate

	// registered settings driven out to the stream receivers
	// the extra stage keeps decode logic off the pins at the cost of one cycle of lag
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			in_ofs_reg <= 24'h000000;
			flag_reg   <= 8'h00;
		end else begin
			in_ofs_reg <= in_ofs_wire;
			flag_reg   <= flag_wire;
		end
	end

	// ==========================================================
	// outputs
	assign PRDATA             = prdata_reg;
	assign PREADY             = pready_reg;
	assign PSLVERR            = pslverr_reg;
	assign IRQ                = irq_reg;
	assign STREAM_IN_OFFSET   = in_ofs_reg;
	assign STREAM_OFFSET_FLAG = flag_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);

	a_apb_one_wait:        assert property ((apb_access && !pready_reg) |=> PREADY)
		else $error("pready not one cycle after access start");
	a_ro_fields_kept:      assert property ((wr_en && hit_align && meas.done && meas.start)
	                                       |=> ($stable(meas.count) && $stable(meas.done) && $stable(meas.phase)))
		else $error("read-only field moved on a processor write");
	a_select_written:      assert property ((wr_en && hit_align && PSTRB[1]) |=> sel_reg == $past(PWDATA[15:11]))
		else $error("select field not written");
	a_done_sets_status:    assert property (meas.done_pulse |=> irq_stat_reg)
		else $error("completion did not set status");
	a_irq_follows_mask:    assert property (IRQ == (irq_stat_reg && irq_mask_reg))
		else $error("interrupt output wrong");
	a_stream_nibble_map:   assert property (##1 STREAM_IN_OFFSET[2:0] == $past(ofs0_reg[3:1]))
		else $error("stream 0 offset misplaced");
	a_read_shows_count:    assert property ((apb_access && !pready_reg && !PWRITE && hit_align)
	                                       |=> PRDATA[8:0] == $past(meas.count))
		else $error("read data lacks count");
	// handshake details that software relies on
	a_ready_one_cycle:     assert property (PREADY |=> !PREADY)
		else $error("pready held longer than one cycle");
	a_unmapped_errs:       assert property ((apb_access && !pready_reg && !hit_any)
	                                       |=> (PSLVERR && PRDATA == fom_pkg::RD_ZERO))
		else $error("unmapped access not refused");
	a_upper_half_zero:     assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_unmapped_ignored:    assert property ((wr_en && !hit_any)
	                                       |=> ($stable(sel_reg) && $stable(start_reg) &&
	                                            $stable(ofs0_reg) && $stable(ofs1_reg)))
		else $error("unmapped write changed a register");
	// software registers and the interrupt path
	a_start_written:       assert property ((wr_en && hit_mode && PSTRB[0])
	                                       |=> start_reg == $past(PWDATA[fom_pkg::START_BIT]))
		else $error("start bit not written");
	a_mask_written:        assert property ((wr_en && hit_mask && PSTRB[0])
	                                       |=> irq_mask_reg == $past(PWDATA[fom_pkg::IRQ_DONE_BIT]))
		else $error("mask bit not written");
	a_status_w1c:          assert property ((wr_en && hit_stat && PSTRB[0] && PWDATA[0] && !meas.done_pulse)
	                                       |=> !irq_stat_reg)
		else $error("status bit not cleared by a one");
	// stream settings fan-out, one cycle behind the registers
	a_flag_nibble_map:     assert property (##1 STREAM_OFFSET_FLAG[0] == $past(ofs0_reg[0]))
		else $error("stream 0 flag misplaced");
	a_high_stream_map:     assert property (##1 STREAM_IN_OFFSET[23:21] == $past(ofs1_reg[15:13]))
		else $error("stream 7 offset misplaced");

	c_read_complete:  cover property (apb_done && hit_align && meas.done);
	c_irq_raised:     cover property ($rose(IRQ));
	c_clear_race:     cover property (meas.done_pulse && wr_en && hit_stat);

endmodule

// ---- testbench/fom_src.sv ----
// stream source model: free bit clock, device frame pulse, evaluation lines
// assumes the bench raises fire once the start bit is written
`timescale 1ns/10ps
module fom_src (
	// control from the bench
	input  wire logic       clk,
	input  wire logic       fire,
	input  wire logic [4:0] sel,
	input  wire logic [8:0] dly,
	input  wire logic       ph,
	// pins toward the block
	output logic [23:0]     lines,
	output logic            bclk,
	output logic            fs_n
);
	// ==========================================
	// bit clock runs free, 16 system cycles a period
	initial begin
		lines = 24'hffffff;
		bclk = 1'b0;
		fs_n = 1'b1;
		forever begin
			repeat (8) @(posedge clk);
			bclk <= ~bclk;
		end
	end
	// decoys fall early so a wrong select reads zero
	always @(posedge fire) begin
		@(negedge bclk);
		fs_n <= 1'b0;
		repeat (4) @(posedge clk);
		fs_n <= 1'b1;
		lines <= 24'h1 << sel;
		repeat (dly) @(negedge bclk);
		repeat (ph ? 12 : 4) @(posedge clk); // mid-phase, clear of sync skew
		lines[sel] <= 1'b0;
	end
	// lines go idle when the request is withdrawn
	always @(negedge fire) lines <= 24'hffffff;
endmodule

// ---- testbench/frame_offset_measurement_test.sv ----
// self-checking bench: apb master, read queue with monitor, stream source
// assumes fom_top with one wait state and the register map of fom_pkg
`timescale 1ns/10ps
module frame_offset_measurement_test;
	logic        clk, rst_n, psel, penable, pwrite, fire, ph, pready, pslverr, irq, bclk, fs_n;
	logic [7:0]  paddr, flg;
	logic [31:0] pwdata, prdata;
	logic [23:0] lines, ofs;
	logic [4:0]  sel;
	logic [8:0]  dly;
	logic [15:0] v [2];
	logic [32:0] e;
	logic [32:0] expq [$];
	int          mismatches, checks_done, seed, n;
	// ==========================================
	// design and far side
	fom_top fom_top_i (.CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.IRQ(irq), .EVAL_INPUT_LINES(lines), .BIT_CLK(bclk), .FRAME_SYNC_N(fs_n),
		.STREAM_IN_OFFSET(ofs), .STREAM_OFFSET_FLAG(flg));
	fom_src fom_src_i (.clk(clk), .fire(fire), .sel(sel), .dly(dly), .ph(ph), .lines(lines),
		.bclk(bclk), .fs_n(fs_n));
	task chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [32:0] x);
		expq.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// monitor: oldest note against each completed read
	always @(posedge clk)
		if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, expq.pop_front());
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// watchdog beyond three frame gaps and one saturated count
	initial begin
		repeat (95000) @(posedge clk);
		mismatches++;
		final_report();
	end
	// ==========================================
	// main sequence
	initial begin
		{psel, penable, pwrite, fire, ph, rst_n} = '0;
		paddr = '0;
		pwdata = '0;
		sel = '0;
		dly = 9'h1;
		seed = 78;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b1, 8'h18, 32'hffff_ffff); // unmapped write must change nothing
		for (int a = 0; a < 6; a++) rd(8'(a * 4), 33'h0);
		rd(8'h18, {1'b1, 32'h0}); // unmapped place is refused
		for (int i = 0; i < 2; i++) begin
			v[i] = 16'($random(seed));
			apb(1'b1, 8'(8 + i * 4), {16'h0, v[i]});
			rd(8'(8 + i * 4), {17'h0, v[i]});
		end
		for (int s = 0; s < 8; s++) begin
			chk(ofs[3*s +: 3], v[s/4][4*(s%4)+1 +: 3]);
			chk(flg[s], v[s/4][4*(s%4)]);
		end
		apb(1'b1, fom_pkg::ADDR_IRQ_MASK, 32'h1);
		for (int k = 0; k < 4; k++) begin
			sel = (k == 0) ? 5'h00 : (k == 1) ? 5'h17 : (k == 2) ? 5'($unsigned($random(seed)) % 24) : 5'h18;
			dly = 9'(1 + $unsigned($random(seed)) % 40);
			ph = k[0];
			apb(1'b1, 8'h00, {16'h0, sel, 11'h0});
			apb(1'b1, 8'h04, 32'h1);
			fire <= 1'b1;
			n = 0;
			while (irq !== 1'b1 && n < 20000) begin
				@(posedge clk);
				n++;
			end
			e = (k == 3) ? {17'h0, sel, 2'b11, 9'h1ff} : {17'h0, sel, 1'b1, ph, 9'(dly + ph)};
			rd(8'h00, e);
			apb(1'b1, 8'h00, {16'h0, sel, 11'h7ff});
			rd(8'h00, e);
			apb(1'b1, 8'h14, 32'h0);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
			apb(1'b1, 8'h14, 32'h1);
			repeat (2) @(posedge clk);
			chk(irq, 1'b1);
			apb(1'b1, 8'h04, 32'h0);
			fire <= 1'b0;
			rd(8'h00, {17'h0, sel, 11'h0});
			apb(1'b1, 8'h10, 32'h1);
			rd(8'h10, 33'h0);
			chk(irq, 1'b0);
			if (k < 3) repeat (25000) @(posedge clk);
		end
		final_report();
	end
endmodule
